// [pci_defs.svh]
// constants of the parameter command interpreter
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH
`define PCI_OP_GET_AXIS      8'h06
`define PCI_OP_STORE_AXIS    8'h07
`define PCI_OP_RESTORE_AXIS  8'h08
`define PCI_OP_SET_GLOBAL    8'h09
`define PCI_OP_GET_GLOBAL    8'h0a
`define PCI_BANK_MODULE      8'h00
`define PCI_BANK_USER        8'h02
`define PCI_BANK_IRQ         8'h03
`define PCI_ST_OK            8'h64
`define PCI_ST_BAD_SUM       8'h01
`define PCI_ST_BAD_OP        8'h02
`define PCI_ST_BAD_TYPE      8'h03
`define PCI_ST_BAD_VALUE     8'h04
`define PCI_FRAME_LEN        4'h9
`define PCI_REPLY_ADDR       8'h02
`define PCI_MODULE_ADDR      8'h01
`endif

// [pci_pkg.sv]
// types of the parameter command interpreter
package pci_pkg;
   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  op;
      logic [7:0]  ptype;
      logic [7:0]  bank;
      logic [31:0] value;
   } pci_frame_t;
   typedef struct packed {
      logic [7:0]  reply_addr;
      logic [7:0]  module_addr;
      logic [7:0]  status;
      logic [7:0]  op;
      logic [31:0] value;
   } pci_reply_t;
   typedef enum logic [1:0] {PCI_NV_IDLE, PCI_NV_WRITE, PCI_NV_READ} pci_nv_op_t;
endpackage : pci_pkg

// [pci_frame_rx.sv]
// frame assembler: collects nine bytes and checks the checksum
`include "pci_defs.svh"
module pci_frame_rx (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              byte_valid,
   input  wire logic [7:0]        byte_data,
   input  wire logic              abort,
   output pci_pkg::pci_frame_t    frame,
   output logic                   frame_valid,
   output logic                   sum_ok
);
   import pci_pkg::*;
   logic [3:0]  cnt_r;
   logic [63:0] shift_r;
   logic [7:0]  sum_r;
   wire         last_byte = byte_valid && (cnt_r == (`PCI_FRAME_LEN - 4'h1));

   always_ff @(posedge clk) begin
      if (rst || abort) begin
         cnt_r       <= 4'h0;
         sum_r       <= 8'h00;
         frame_valid <= 1'b0;
         sum_ok      <= 1'b0;
         shift_r     <= 64'h0;
      end else begin
         frame_valid <= last_byte;
         if (byte_valid) begin
            if (last_byte) begin
               cnt_r  <= 4'h0;
               sum_r  <= 8'h00;
               sum_ok <= (byte_data == sum_r);
            end else begin
               cnt_r   <= cnt_r + 4'h1;
               sum_r   <= sum_r + byte_data;
               shift_r <= {shift_r[55:0], byte_data};
            end
         end
      end
   end

   assign frame = pci_frame_t'(shift_r);
endmodule : pci_frame_rx

// [pci_interp.sv]
// parameter command interpreter: axis and global parameter reads, global writes, axis store, restore
`include "pci_defs.svh"
module pci_interp #(
   parameter int AXIS_PARAMS   = 16,
   parameter int GLOBAL_PARAMS = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              byte_valid,
   input  wire logic [7:0]        byte_data,
   input  wire logic              frame_abort,
   input  wire logic              standalone,
   input  wire logic              nv_busy,
   input  wire logic [31:0]       nv_rdata,
   input  wire logic              nv_rvalid,
   output pci_pkg::pci_reply_t    reply,
   output logic                   reply_valid,
   output logic                   nv_req,
   output pci_pkg::pci_nv_op_t    nv_op,
   output logic                   nv_is_global,
   output logic [7:0]             nv_index,
   output logic [31:0]            nv_wdata,
   output logic [31:0]            accu,
   output logic                   boot_done
);
   import pci_pkg::*;
   localparam int AW = $clog2(AXIS_PARAMS);
   localparam int GW = $clog2(GLOBAL_PARAMS);
   // type indices are cut to table width only after the range check

   // boot reload runs first; frames finished before it ends get no reply
   typedef enum {PCI_BOOT_REQ, PCI_BOOT_WAIT, PCI_IDLE, PCI_NV_REQ, PCI_NV_WAIT} pci_state_t;

   pci_frame_t  frm;
   logic        frm_valid;
   logic        frm_sum_ok;
   pci_state_t  state_r;
   logic [31:0] axis_r   [AXIS_PARAMS];
   logic [31:0] gmod_r   [GLOBAL_PARAMS];
   logic [31:0] guser_r  [GLOBAL_PARAMS];
   logic [31:0] girq_r   [GLOBAL_PARAMS];
   logic [AW-1:0] boot_idx_r;
   logic [AW-1:0] pend_idx_r;
   logic        pend_restore_r;

   pci_frame_rx u_rx (
      .clk         (clk),
      .rst         (rst),
      .byte_valid  (byte_valid),
      .byte_data   (byte_data),
      .abort       (frame_abort),
      .frame       (frm),
      .frame_valid (frm_valid),
      .sum_ok      (frm_sum_ok)
   );

   function automatic logic bank_known(input logic [7:0] b);
      return (b == `PCI_BANK_MODULE) || (b == `PCI_BANK_USER) || (b == `PCI_BANK_IRQ);
   endfunction : bank_known

   // decode of the received frame
   wire         is_get_axis  = frm.op == `PCI_OP_GET_AXIS;
   wire         is_store     = frm.op == `PCI_OP_STORE_AXIS;
   wire         is_restore   = frm.op == `PCI_OP_RESTORE_AXIS;
   wire         is_set_glob  = frm.op == `PCI_OP_SET_GLOBAL;
   wire         is_get_glob  = frm.op == `PCI_OP_GET_GLOBAL;
   wire         is_axis_op   = is_get_axis || is_store || is_restore;
   wire         is_glob_op   = is_set_glob || is_get_glob;
   wire         axis_bank_ok = frm.bank == 8'h00;
   wire         axis_ok      = (frm.ptype < 8'(AXIS_PARAMS)) && axis_bank_ok;
   wire         glob_ok      = (frm.ptype < 8'(GLOBAL_PARAMS)) && bank_known(frm.bank);
   wire [AW-1:0] aidx        = frm.ptype[AW-1:0];
   wire [GW-1:0] gidx        = frm.ptype[GW-1:0];
   wire [31:0]  axis_rd      = axis_r[aidx];
   wire         bank_is_mod  = frm.bank == `PCI_BANK_MODULE;
   wire         bank_is_user = frm.bank == `PCI_BANK_USER;
   wire         bank_is_irq  = frm.bank == `PCI_BANK_IRQ;
   wire [31:0]  glob_rd      = bank_is_mod  ? gmod_r[gidx] :
                               bank_is_user ? guser_r[gidx] : girq_r[gidx];
   // frames that complete during a memory transfer are dropped, never queued
   wire         accept       = frm_valid && (state_r == PCI_IDLE);
   wire         known_op     = is_axis_op || is_glob_op;
   wire         fields_ok    = is_axis_op ? axis_ok : glob_ok;
   wire         cmd_ok       = accept && frm_sum_ok && known_op && fields_ok;
   // first failing check decides: sum, op, bank, then type
   wire [7:0]   bad_status   = !frm_sum_ok ? `PCI_ST_BAD_SUM :
                               !known_op   ? `PCI_ST_BAD_OP :
                               (is_axis_op && !axis_bank_ok) ? `PCI_ST_BAD_VALUE :
                               (is_glob_op && !bank_known(frm.bank)) ? `PCI_ST_BAD_VALUE : `PCI_ST_BAD_TYPE;
   wire         nv_axis_cmd  = cmd_ok && (is_store || is_restore);
   wire         glob_write   = cmd_ok && is_set_glob;
   wire         bank0_write  = glob_write && bank_is_mod;
   wire         is_read      = is_get_axis || is_get_glob;
   wire [31:0]  read_val     = is_get_axis ? axis_rd : glob_rd;
   // reads update the accumulator only when running a stored program
   wire         accu_load    = cmd_ok && standalone && is_read;
   wire [7:0]   status_nxt   = cmd_ok ? `PCI_ST_OK : bad_status;
   // refused frames and non-read commands answer with a zero value
   wire [31:0]  value_nxt    = (cmd_ok && is_read) ? read_val : 32'h0;
   wire         boot_launch  = (state_r == PCI_BOOT_REQ) && !nv_busy;
   wire         nv_launch    = (state_r == PCI_NV_REQ) && !nv_busy;
   wire         boot_last    = boot_idx_r == AW'(AXIS_PARAMS - 1);
   // a write is over only once the memory has taken the request and dropped busy;
   // busy alone still reads low in the cycle the request is in flight
   wire         nv_wr_done   = !nv_busy && !nv_req;
   wire         nv_done      = pend_restore_r ? nv_rvalid : nv_wr_done;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r        <= PCI_BOOT_REQ;
         boot_idx_r     <= '0;
         pend_idx_r     <= '0;
         pend_restore_r <= 1'b0;
         boot_done      <= 1'b0;
      end else begin
         unique case (state_r)
            PCI_BOOT_REQ:  if (boot_launch) state_r <= PCI_BOOT_WAIT;
            PCI_BOOT_WAIT: if (nv_rvalid) begin
               if (boot_last) begin
                  state_r   <= PCI_IDLE;
                  boot_done <= 1'b1;
               end else begin
                  state_r <= PCI_BOOT_REQ;
               end
               boot_idx_r <= boot_idx_r + AW'(1);
            end
            PCI_IDLE: if (nv_axis_cmd) begin
               state_r        <= PCI_NV_REQ;
               pend_idx_r     <= aidx;
               pend_restore_r <= is_restore;
            end else if (bank0_write) begin
               state_r <= PCI_NV_REQ;
            end
            PCI_NV_REQ:  if (nv_launch) state_r <= PCI_NV_WAIT;
            PCI_NV_WAIT: if (nv_done) begin
               state_r        <= PCI_IDLE;
               pend_restore_r <= 1'b0;
            end
         endcase
      end
   end

   // non-volatile request port; one request per transfer
   // store and save fields settle a cycle ahead of their request
   always_ff @(posedge clk) begin
      if (rst) begin
         nv_req       <= 1'b0;
         nv_op        <= PCI_NV_IDLE;
         nv_is_global <= 1'b0;
         nv_index     <= 8'h00;
         nv_wdata     <= 32'h0;
      end else begin
         nv_req <= 1'b0;
         if (boot_launch) begin
            nv_req       <= 1'b1;
            nv_op        <= PCI_NV_READ;
            nv_is_global <= 1'b0;
            nv_index     <= 8'(boot_idx_r);
         end else if (nv_axis_cmd) begin
            nv_op        <= is_restore ? PCI_NV_READ : PCI_NV_WRITE;
            nv_is_global <= 1'b0;
            nv_index     <= frm.ptype;
            nv_wdata     <= axis_rd;
         end else if (bank0_write) begin
            nv_op        <= PCI_NV_WRITE;
            nv_is_global <= 1'b1;
            nv_index     <= frm.ptype;
            nv_wdata     <= frm.value;
         end else if (nv_launch) begin
            nv_req <= 1'b1;
         end
      end
   end

   // parameter storage; restore and boot writes land from the memory read data
   // boot and restore never overlap, so one load path per slot suffices
   genvar gi;
   generate
      for (gi = 0; gi < AXIS_PARAMS; gi++) begin : g_axis
         wire boot_hit = state_r == PCI_BOOT_WAIT && nv_rvalid && boot_idx_r == AW'(gi);
         wire rest_hit = state_r == PCI_NV_WAIT && pend_restore_r && nv_rvalid && pend_idx_r == AW'(gi);
         always_ff @(posedge clk) begin
            if (rst) axis_r[gi] <= 32'h0;
            else if (boot_hit || rest_hit) axis_r[gi] <= nv_rdata;
         end
      end
      // globals: one slot per index in each bank; the bank picks the copy written
      for (gi = 0; gi < GLOBAL_PARAMS; gi++) begin : g_glob
         wire hit = glob_write && gidx == GW'(gi);
         always_ff @(posedge clk) begin
            if (rst) begin
               gmod_r[gi]  <= 32'h0;
               guser_r[gi] <= 32'h0;
               girq_r[gi]  <= 32'h0;
            end else if (hit) begin
               if (bank_is_mod)  gmod_r[gi] <= frm.value;
               if (bank_is_user) guser_r[gi] <= frm.value;
               if (bank_is_irq)  girq_r[gi] <= frm.value;
            end
         end
      end
   endgenerate

   // reply and accumulator; dropped frames leave both untouched
   always_ff @(posedge clk) begin
      if (rst) begin
         reply       <= '0;
         reply_valid <= 1'b0;
         accu        <= 32'h0;
      end else begin
         reply_valid <= accept;
         if (accu_load) accu <= read_val;
         if (accept) begin
            reply.reply_addr  <= `PCI_REPLY_ADDR;
            reply.module_addr <= `PCI_MODULE_ADDR;
            reply.op          <= frm.op;
            reply.status      <= status_nxt;
            reply.value       <= value_nxt;
         end
      end
   end
endmodule : pci_interp

// [pci_nv_model.sv]
// stand-in for the non-volatile parameter memory
module pci_nv_model import pci_pkg::*; #(
   parameter int DLY = 2
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 nv_req,
   input  wire pci_pkg::pci_nv_op_t  nv_op,
   input  wire logic                 nv_is_global,
   input  wire logic [7:0]           nv_index,
   input  wire logic [31:0]          nv_wdata,
   output logic                      nv_busy,
   output logic [31:0]               nv_rdata,
   output logic                      nv_rvalid
);
   logic [31:0] mem [16];
   logic [31:0] gmem [16];
   logic [3:0]  idx;
   logic        rd;
   int          cnt;
   int          ops;
   initial for (int i = 0; i < 16; i++) mem[i] = 32'hc0de0000 + 32'(i);
   always @(posedge clk) begin
      nv_rvalid <= 1'b0;
      // read data churns outside the valid pulse
      nv_rdata <= ~nv_rdata;
      if (rst) begin
         nv_busy <= 1'b0;
         cnt <= 0;
         ops <= 0;
         nv_rdata <= 32'h5a5a5a5a;
      end else if (nv_req && !nv_busy) begin
         nv_busy <= 1'b1;
         // latency varies with the index
         cnt <= DLY + int'(nv_index[1:0]);
         idx <= nv_index[3:0];
         rd <= (nv_op == PCI_NV_READ);
         if (nv_op == PCI_NV_WRITE && nv_is_global) gmem[nv_index[3:0]] <= nv_wdata;
         else if (nv_op == PCI_NV_WRITE) mem[nv_index[3:0]] <= nv_wdata;
      end else if (cnt > 1) cnt <= cnt - 1;
      else if (nv_busy) begin
         nv_busy <= 1'b0;
         nv_rvalid <= rd;
         ops <= ops + 1;
         if (rd) nv_rdata <= mem[idx];
      end
   end
endmodule : pci_nv_model

// [pci_interp_sva.sv]
// port assertions of the parameter command interpreter
`include "pci_defs.svh"
module pci_interp_chk import pci_pkg::*; (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 byte_valid,
   input wire logic                 standalone,
   input wire pci_pkg::pci_reply_t  reply,
   input wire logic                 reply_valid,
   input wire logic                 nv_req,
   input wire pci_pkg::pci_nv_op_t  nv_op,
   input wire logic                 nv_is_global,
   input wire logic [31:0]          accu,
   input wire logic                 boot_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire ok = reply_valid && reply.status == `PCI_ST_OK;
   property p_lat; reply_valid |-> $past(byte_valid, 2); endproperty
   a_lat: assert property (p_lat) else $error("reply not two cycles after a byte");
   property p_accu; ok && standalone && (reply.op == `PCI_OP_GET_AXIS || reply.op == `PCI_OP_GET_GLOBAL)
      |-> ##[0:1] accu == reply.value; endproperty
   a_accu: assert property (p_accu) else $error("accumulator not loaded by read");
   property p_keep; !standalone [*3] |-> $stable(accu); endproperty
   a_keep: assert property (p_keep) else $error("accumulator moved in direct mode");
   property p_err; reply_valid && reply.status != `PCI_ST_OK |-> reply.value == 32'h0; endproperty
   a_err: assert property (p_err) else $error("refused frame carries a value");
   property p_store; ok && reply.op == `PCI_OP_STORE_AXIS
      |-> nv_op == PCI_NV_WRITE && !nv_is_global ##[1:40] nv_req; endproperty
   a_store: assert property (p_store) else $error("store issued no memory write");
   property p_rest; ok && reply.op == `PCI_OP_RESTORE_AXIS |-> nv_op == PCI_NV_READ ##[1:40] nv_req; endproperty
   a_rest: assert property (p_rest) else $error("restore issued no memory read");
   property p_glob; nv_req && nv_is_global |-> nv_op == PCI_NV_WRITE && boot_done; endproperty
   a_glob: assert property (p_glob) else $error("global save is not a write");
   property p_boot; reply_valid || (nv_req && nv_op == PCI_NV_WRITE) |-> boot_done; endproperty
   a_boot: assert property (p_boot) else $error("activity before reload finished");
   c_axis: cover property (ok && reply.op == `PCI_OP_GET_AXIS);
   c_save: cover property (nv_req && nv_is_global);
   c_bad: cover property (reply_valid && reply.status == `PCI_ST_BAD_SUM);
endmodule : pci_interp_chk
bind pci_interp pci_interp_chk chk (.clk, .rst, .byte_valid, .standalone, .reply, .reply_valid,
   .nv_req, .nv_op, .nv_is_global, .accu, .boot_done);

// [pci_interp_test.sv]
// self-checking bench of the parameter command interpreter
`include "pci_defs.svh"
module pci_interp_test import pci_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, byte_valid = 0, standalone = 0, frame_abort = 0;
   logic [7:0]  byte_data = 8'h00;
   logic        nv_busy, nv_rvalid, nv_req, nv_is_global, reply_valid, boot_done;
   logic [31:0] nv_rdata, nv_wdata, accu, v;
   logic [7:0]  nv_index;
   pci_reply_t  reply;
   pci_nv_op_t  nv_op;
   logic [48:0] exp_q[$];
   logic [48:0] e;
   logic [31:0] seed = 32'hfea2;
   int          err_count = 0, n_compared = 0, cyc = 0, n0;
   pci_interp uut (.clk, .rst, .byte_valid, .byte_data, .frame_abort, .standalone, .nv_busy, .nv_rdata,
      .nv_rvalid, .reply, .reply_valid, .nv_req, .nv_op, .nv_is_global, .nv_index, .nv_wdata, .accu, .boot_done);
   pci_nv_model nv (.clk, .rst, .nv_req, .nv_op, .nv_is_global, .nv_index, .nv_wdata, .nv_busy, .nv_rdata,
      .nv_rvalid);
   always #5 clk = ~clk;
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      n_compared++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic conclude();
      if (exp_q.size() != 0) err_count++;
      $display("errors=%0d compared=%0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // dc: reply value not compared unless it holds X or Z
   task automatic send(input logic [7:0] op, t, b, input logic [31:0] val, input logic [7:0] st,
                       input logic [31:0] rv, input logic dc = 0, input logic bad = 0);
      logic [71:0] f;
      logic [31:0] r;
      f = {8'h01, op, t, b, val, 8'h00};
      for (int i = 1; i < 9; i++) f[7:0] += f[i*8 +: 8];
      f[0] ^= bad;
      exp_q.push_back({op, dc, st, rv});
      for (int i = 8; i >= 0; i--) begin
         byte_valid = 1;
         byte_data = f[i*8 +: 8];
         @(posedge clk) #1;
      end
      byte_valid = 0;
      r = xs();
      byte_data = r[7:0];
      repeat (4) @(posedge clk) #1;
   endtask : send
   task automatic wait_nv(input int want);
      // want 0 waits the full span so a stray memory access is still seen
      for (int i = 0; i < 60 && nv.ops == n0; i++) @(posedge clk) #1;
      check(40'(nv.ops - n0), 40'(want));
   endtask : wait_nv
   always @(negedge clk) if (reply_valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      check({reply.status, reply.value}, {e[39:32], e[40] && !$isunknown(reply.value) ? reply.value : e[31:0]});
      check(40'({reply.reply_addr, reply.module_addr, reply.op}),
            40'({`PCI_REPLY_ADDR, `PCI_MODULE_ADDR, e[48:41]}));
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 0;
      for (int i = 0; i < 600 && boot_done !== 1'b1; i++) @(posedge clk) #1;
      check({39'h0, boot_done}, 40'h1);
      for (int t = 0; t < 16; t++) send(`PCI_OP_GET_AXIS, 8'(t), 0, xs(), `PCI_ST_OK, 32'hc0de0000 + 32'(t));
      check({8'h00, accu}, 40'h0);
      standalone = 1;
      send(`PCI_OP_GET_AXIS, 3, 0, 0, `PCI_ST_OK, 32'hc0de0003);
      check({8'h00, accu}, 40'hc0de0003);
      for (int j = 0; j < 4; j++) if (j != 1) begin
         v = xs();
         n0 = nv.ops;
         send(`PCI_OP_SET_GLOBAL, 8'(j + 4), 8'(j), v, `PCI_ST_OK, 0, 1);
         wait_nv(j == 0);
         if (j == 0) check({8'h00, nv.gmem[4]}, {8'h00, v});
         send(`PCI_OP_GET_GLOBAL, 8'(j + 4), 8'(j), xs(), `PCI_ST_OK, v);
         check({8'h00, accu}, {8'h00, v});
      end
      nv.mem[2] = 0;
      n0 = nv.ops;
      send(`PCI_OP_STORE_AXIS, 2, 0, xs(), `PCI_ST_OK, 0, 1);
      wait_nv(1);
      check({8'h00, nv.mem[2]}, 40'hc0de0002);
      nv.mem[5] = xs();
      n0 = nv.ops;
      send(`PCI_OP_RESTORE_AXIS, 5, 0, 0, `PCI_ST_OK, 0, 1);
      wait_nv(1);
      send(`PCI_OP_GET_AXIS, 5, 0, 0, `PCI_ST_OK, nv.mem[5]);
      // a cut frame must not swallow the head of the next one
      byte_valid = 1;
      repeat (4) @(posedge clk) #1;
      byte_valid = 0;
      frame_abort = 1;
      @(posedge clk) #1;
      frame_abort = 0;
      send(`PCI_OP_GET_AXIS, 5, 0, 0, `PCI_ST_OK, nv.mem[5]);
      send(`PCI_OP_GET_AXIS, 1, 0, 0, `PCI_ST_BAD_SUM, 0, 0, 1);
      send(8'h05, 1, 0, 0, `PCI_ST_BAD_OP, 0);
      send(`PCI_OP_GET_AXIS, 8'h10, 0, 0, `PCI_ST_BAD_TYPE, 0);
      send(`PCI_OP_STORE_AXIS, 2, 1, 0, `PCI_ST_BAD_VALUE, 0);
      send(`PCI_OP_SET_GLOBAL, 1, 1, xs(), `PCI_ST_BAD_VALUE, 0);
      conclude();
   end
endmodule : pci_interp_test
